// [src/rfse_regs.vh]
// Register offsets, field positions and reset values of the fault
// status and fault event block. Assumes a 32-bit APB register bus.
`ifndef RFSE_REGS_VH
`define RFSE_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RFSE_OFS_FAULT_STATUS 12'h034
`define RFSE_OFS_FAULT_EVENT_CONTROL 12'h038
`define RFSE_OFS_IRQ_STATUS 12'h050
`define RFSE_OFS_IRQ_MASK 12'h054

// ----------------------------------------------------------------
// Fault status fields
// ----------------------------------------------------------------
`define RFSE_FS_PRIMARY_OVERFLOW 0
`define RFSE_FS_PRIMARY_PENDING 1
`define RFSE_FS_ADVANCED_OVERFLOW 2
`define RFSE_FS_ADVANCED_PENDING 3
`define RFSE_FS_QUEUE_ERROR 4
`define RFSE_FS_INDEX_LSB 8
`define RFSE_FS_RESET 32'h00000000

// ----------------------------------------------------------------
// Fault event control fields
// ----------------------------------------------------------------
`define RFSE_FEC_MASK_BIT 31
`define RFSE_FEC_PENDING_BIT 30
`define RFSE_FEC_RESET 32'h80000000

// ----------------------------------------------------------------
// Interrupt status and mask bits
// ----------------------------------------------------------------
`define RFSE_IRQ_QUEUE_ERROR 0
`define RFSE_IRQ_ADV_PENDING 1
`define RFSE_IRQ_ADV_OVERFLOW 2
`define RFSE_IRQ_PRI_PENDING 3
`define RFSE_IRQ_PRI_OVERFLOW 4
`define RFSE_IRQ_MSG_SENT 5
`define RFSE_IRQ_W 6
`define RFSE_IRQ_MASK_RESET 6'h00

`endif

// [src/rfse_w1c_flag.v]
// Sticky flag: set by hardware, cleared by a write of one.
// Assumes set and clear are single-cycle strobes on clk_in.
module rfse_w1c_flag #(
  parameter IMPL = 1
) (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Set and clear strobes
  input wire set_in,
  input wire clr_in,
  // Flag
  output reg flag_out
);

  // Set wins over a clear in the same cycle
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      flag_out <= 1'b0;
    else if (IMPL == 0)
      flag_out <= 1'b0;
    else if (set_in)
      flag_out <= 1'b1;
    else if (clr_in)
      flag_out <= 1'b0;
  end

endmodule

// [src/rfse_apb_if.v]
// APB slave handshake: one wait state, registered read data.
// Assumes the top decodes the address and supplies read data.
module rfse_apb_if (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // APB control
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  // Decode from the register file
  input wire hit_in,
  input wire [31:0] rdata_in,
  // APB answer
  output reg pready_out,
  output reg [31:0] prdata_out,
  output reg pslverr_out,
  // Write strobe, valid at the completing edge
  output wire wr_stb_out
);

  wire access;

  assign access = psel_in & penable_in & ~pready_out;
  assign wr_stb_out = psel_in & penable_in & pready_out & pwrite_in &
    hit_in;

  // ----------------------------------------------------------------
  // Answer one cycle into the access phase
  // ----------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pready_out <= 1'b0;
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= access;
      if (access)
      begin
        prdata_out <= (hit_in && !pwrite_in) ? rdata_in : 32'h00000000;
        pslverr_out <= ~hit_in;
      end
      else
      begin
        pslverr_out <= 1'b0;
      end
    end
  end

endmodule

// [src/rfse_top.v]
// Fault status flags and fault event signalling of a remapping unit.
// Assumes an APB master on clk_in and fault sources synchronous to it.
`include "rfse_regs.vh"

// What this block does
// - Set queue error on fetch or descriptor error
// - Queue error may raise a fault event
// - Queue error reserved without queued invalidation
// - First advanced record sets pending, raises event
// - Write one clears advanced pending flag
// - Advanced overflow sets flag, event, w1c
// - Advanced flags reserved: feature not supported
// - Primary pending is OR of record flags
// - Record index updated when pending set
// - Primary pending set raises a fault event
// - Record overflow sets primary overflow flag
// - Primary overflow cleared only by write one
// - Event control register resets to 80000000h
// - No event message while mask bit set
// - Pending bit set on each new condition
// - Index names record of first pending fault
module rfse_top #(
  parameter NFR = 8,
  parameter IDX_W = 8,
  parameter QI_SUPPORT = 1,
  parameter ADV_SUPPORT = 0
) (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire pready_out,
  output wire [31:0] prdata_out,
  output wire pslverr_out,
  // Invalidation queue errors
  input wire iq_fetch_err_in,
  input wire iq_desc_err_in,
  // Advanced fault log events
  input wire adv_first_rec_in,
  input wire adv_overflow_in,
  // Fault recording registers
  input wire [NFR-1:0] fault_flags_in,
  input wire rec_overflow_in,
  // Fault event message and interrupt
  output reg fault_msg_out,
  output reg irq_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wire wr_stb;
  wire sel_status;
  wire sel_control;
  wire sel_ists;
  wire sel_imask;
  reg hit;
  reg [31:0] rdata;

  wire queue_error_flag;
  wire advanced_pending_flag;
  wire advanced_overflow_flag;
  wire primary_overflow_flag;
  reg primary_pending_flag;
  reg [IDX_W-1:0] fault_record_index;
  reg [IDX_W-1:0] next_index;

  reg event_mask_bit;
  reg event_pending_bit;
  reg next_pending;

  wire qe_set;
  wire ap_set;
  wire ao_set;
  wire pp_any;
  wire pp_rise;
  wire qe_new;
  wire ap_new;
  wire ao_new;
  wire po_new;
  wire new_cond;
  wire msg_send;
  wire any_flag;
  wire status_wr;

  wire [`RFSE_IRQ_W-1:0] irq_events;
  wire [`RFSE_IRQ_W-1:0] irq_status;
  reg [`RFSE_IRQ_W-1:0] irq_mask;

  integer i;

  localparam [31:0] FEC_RESET_VAL = `RFSE_FEC_RESET;

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  rfse_apb_if u_apb (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .hit_in(hit),
    .rdata_in(rdata),
    .pready_out(pready_out),
    .prdata_out(prdata_out),
    .pslverr_out(pslverr_out),
    .wr_stb_out(wr_stb)
  );

  assign sel_status = (paddr_in == `RFSE_OFS_FAULT_STATUS);
  assign sel_control = (paddr_in == `RFSE_OFS_FAULT_EVENT_CONTROL);
  assign sel_ists = (paddr_in == `RFSE_OFS_IRQ_STATUS);
  assign sel_imask = (paddr_in == `RFSE_OFS_IRQ_MASK);
  assign status_wr = wr_stb & sel_status;

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  always @*
  begin
    hit = 1'b1;
    rdata = 32'h00000000;
    if (sel_status)
    begin
      rdata[`RFSE_FS_PRIMARY_OVERFLOW] = primary_overflow_flag;
      rdata[`RFSE_FS_PRIMARY_PENDING] = primary_pending_flag;
      rdata[`RFSE_FS_ADVANCED_OVERFLOW] = advanced_overflow_flag;
      rdata[`RFSE_FS_ADVANCED_PENDING] = advanced_pending_flag;
      rdata[`RFSE_FS_QUEUE_ERROR] = queue_error_flag;
      rdata[`RFSE_FS_INDEX_LSB +: IDX_W] = fault_record_index;
    end
    else if (sel_control)
    begin
      rdata[`RFSE_FEC_MASK_BIT] = event_mask_bit;
      rdata[`RFSE_FEC_PENDING_BIT] = event_pending_bit;
    end
    else if (sel_ists)
    begin
      rdata[`RFSE_IRQ_W-1:0] = irq_status;
    end
    else if (sel_imask)
    begin
      rdata[`RFSE_IRQ_W-1:0] = irq_mask;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write-one-to-clear status flags
  // ----------------------------------------------------------------
  assign qe_set = iq_fetch_err_in | iq_desc_err_in;
  assign ap_set = adv_first_rec_in & ~advanced_pending_flag;
  assign ao_set = adv_overflow_in;

  // Reserved when queued invalidation is absent
  rfse_w1c_flag #(
    .IMPL(QI_SUPPORT)
  ) u_queue_error (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .set_in(qe_set),
    .clr_in(status_wr & pwdata_in[`RFSE_FS_QUEUE_ERROR]),
    .flag_out(queue_error_flag)
  );

  // Advanced logging absent by default: flags read as zero
  rfse_w1c_flag #(
    .IMPL(ADV_SUPPORT)
  ) u_adv_pending (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .set_in(ap_set),
    .clr_in(status_wr & pwdata_in[`RFSE_FS_ADVANCED_PENDING]),
    .flag_out(advanced_pending_flag)
  );

  rfse_w1c_flag #(
    .IMPL(ADV_SUPPORT)
  ) u_adv_overflow (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .set_in(ao_set),
    .clr_in(status_wr & pwdata_in[`RFSE_FS_ADVANCED_OVERFLOW]),
    .flag_out(advanced_overflow_flag)
  );

  // Only a write of one clears; set wins over clear
  rfse_w1c_flag #(
    .IMPL(1)
  ) u_pri_overflow (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .set_in(rec_overflow_in),
    .clr_in(status_wr & pwdata_in[`RFSE_FS_PRIMARY_OVERFLOW]),
    .flag_out(primary_overflow_flag)
  );

  // ----------------------------------------------------------------
  // Primary pending flag and record index
  // ----------------------------------------------------------------
  assign pp_any = |fault_flags_in;
  assign pp_rise = pp_any & ~primary_pending_flag;

  // Lowest flagged record is taken as the first pending one
  always @*
  begin
    next_index = fault_record_index;
    for (i = NFR - 1; i >= 0; i = i - 1)
    begin
      if (fault_flags_in[i])
        next_index = i[IDX_W-1:0];
    end
  end

  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      primary_pending_flag <= 1'b0;
      fault_record_index <= {IDX_W{1'b0}};
    end
    else
    begin
      primary_pending_flag <= pp_any;
      if (pp_rise)
        fault_record_index <= next_index;
    end
  end

  // ----------------------------------------------------------------
  // Fault event control and message
  // ----------------------------------------------------------------
  // New condition only when a flag goes from clear to set
  assign qe_new = (QI_SUPPORT != 0) & qe_set & ~queue_error_flag;
  assign ap_new = (ADV_SUPPORT != 0) & ap_set;
  assign ao_new = (ADV_SUPPORT != 0) & ao_set &
    ~advanced_overflow_flag;
  assign po_new = rec_overflow_in & ~primary_overflow_flag;
  assign new_cond = qe_new | ap_new | ao_new | pp_rise;
  assign msg_send = event_pending_bit & ~event_mask_bit;
  assign any_flag = primary_pending_flag | queue_error_flag |
    advanced_pending_flag | advanced_overflow_flag;

  always @*
  begin
    next_pending = event_pending_bit;
    if (new_cond)
      next_pending = 1'b1;
    else if (msg_send)
      next_pending = 1'b0;
    else if (!any_flag)
      next_pending = 1'b0;
  end

  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      event_mask_bit <= FEC_RESET_VAL[`RFSE_FEC_MASK_BIT];
      event_pending_bit <= 1'b0;
      fault_msg_out <= 1'b0;
    end
    else
    begin
      if (wr_stb && sel_control)
        event_mask_bit <= pwdata_in[`RFSE_FEC_MASK_BIT];
      event_pending_bit <= next_pending;
      fault_msg_out <= msg_send;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  assign irq_events[`RFSE_IRQ_QUEUE_ERROR] = qe_new;
  assign irq_events[`RFSE_IRQ_ADV_PENDING] = ap_new;
  assign irq_events[`RFSE_IRQ_ADV_OVERFLOW] = ao_new;
  assign irq_events[`RFSE_IRQ_PRI_PENDING] = pp_rise;
  assign irq_events[`RFSE_IRQ_PRI_OVERFLOW] = po_new;
  assign irq_events[`RFSE_IRQ_MSG_SENT] = msg_send;

  genvar g;
  generate
    for (g = 0; g < `RFSE_IRQ_W; g = g + 1)
    begin : g_irq
      rfse_w1c_flag #(
        .IMPL(1)
      ) u_ist (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .set_in(irq_events[g]),
        .clr_in(wr_stb & sel_ists & pwdata_in[g]),
        .flag_out(irq_status[g])
      );
    end
  endgenerate

  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      irq_mask <= `RFSE_IRQ_MASK_RESET;
      irq_out <= 1'b0;
    end
    else
    begin
      if (wr_stb && sel_imask)
        irq_mask <= pwdata_in[`RFSE_IRQ_W-1:0];
      irq_out <= |(irq_status & irq_mask);
    end
  end

endmodule

// [test/rfse_monitor.sv]
// Checker of APB answers, register reads and fault events of rfse_top.
// Assumes it is bound into rfse_top and sees only its ports.
module rfse_monitor #(
  parameter NFR = 8
) (
  // Clock, reset and APB
  input wire clk_in,
  input wire nrst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire pready_out,
  input wire [31:0] prdata_out,
  input wire pslverr_out,
  // Fault side
  input wire [NFR-1:0] fault_flags_in,
  input wire fault_msg_out,
  input wire irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Shadow of mask bits, taken from completed writes
  // ----------------------------------------------------------------
  logic ecm;
  logic [5:0] imask;
  wire wr_done = psel_in && penable_in && pready_out && pwrite_in;
  wire rd_fs = pready_out && !pwrite_in && paddr_in == 12'h034;
  wire rd_ctl = pready_out && !pwrite_in && paddr_in == 12'h038;
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      ecm <= 1'b1;
      imask <= 6'h00;
    end
    else if (wr_done)
    begin
      if (paddr_in == 12'h038)
        ecm <= pwdata_in[31];
      if (paddr_in == 12'h054)
        imask <= pwdata_in[5:0];
    end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  chk_ready_wait: assert property (psel_in && !penable_in |->
    ##[1:4] pready_out)
    else $error("pready late");
  chk_err_decode: assert property (pready_out |-> pslverr_out ==
    !(paddr_in inside {12'h034, 12'h038, 12'h050, 12'h054}))
    else $error("pslverr wrong");
  chk_ctl_read: assert property (rd_ctl |->
    prdata_out[31] == ecm && prdata_out[29:0] == 30'h0)
    else $error("control read wrong");
  chk_fs_rsvd: assert property (rd_fs |-> prdata_out[31:16] == 16'h0 &&
    prdata_out[7:5] == 3'h0 && prdata_out[3:2] == 2'h0)
    else $error("status reserved bits set");
  chk_ppf_or: assert property (rd_fs &&
    fault_flags_in == $past(fault_flags_in, 3) |->
    prdata_out[1] == |fault_flags_in)
    else $error("pending flag not OR of records");
  chk_msg_masked: assert property (fault_msg_out |-> !$past(ecm))
    else $error("message while masked");
  chk_new_fault: assert property ($rose(|fault_flags_in) && !ecm |->
    ##[1:3] fault_msg_out)
    else $error("no message on new fault");
  chk_irq_gate: assert property (irq_out |-> $past(imask) != 6'h00)
    else $error("irq with all masked");
endmodule

bind rfse_top rfse_monitor #(.NFR(NFR)) u_mon (
  .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pready_out(pready_out),
  .prdata_out(prdata_out), .pslverr_out(pslverr_out),
  .fault_flags_in(fault_flags_in), .fault_msg_out(fault_msg_out),
  .irq_out(irq_out));

// [test/testbench.sv]
// Self-checking bench of rfse_top: register access and fault events.
// Assumes rfse_top with default parameters and the bound checker.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, nrst_in = 0, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, iq_fetch_err_in = 0, iq_desc_err_in = 0;
  logic adv_first_rec_in = 0, adv_overflow_in = 0, rec_overflow_in = 0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, rdat;
  logic [7:0] fault_flags_in = 8'h00, v;
  logic rerr;
  wire pready_out, pslverr_out, fault_msg_out, irq_out;
  wire [31:0] prdata_out;
  int failures = 0, compares = 0, msgs = 0, exp_msgs, seed = 78, low, i;

  rfse_top dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out),
    .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .iq_fetch_err_in(iq_fetch_err_in), .iq_desc_err_in(iq_desc_err_in),
    .adv_first_rec_in(adv_first_rec_in),
    .adv_overflow_in(adv_overflow_in), .fault_flags_in(fault_flags_in),
    .rec_overflow_in(rec_overflow_in), .fault_msg_out(fault_msg_out),
    .irq_out(irq_out));

  initial forever #20 clk_in = ~clk_in;
  always @(posedge clk_in) if (fault_msg_out === 1'b1) msgs <= msgs + 1;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("counts compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 16);
    if (pready_out !== 1'b1)
    begin
      failures++;
      tally_and_finish();
    end
    else
    begin
      rdat = prdata_out;
      rerr = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask
  task automatic rd(input string nm, input logic [11:0] a,
    input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, e & m, rdat & m);
    chk({nm, " err"}, 32'h0, {31'h0, rerr});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    tick(8);
    nrst_in <= 1'b1;
    rd("status", 12'h034, 32'h0, 32'hffffffff);
    rd("control", 12'h038, 32'h80000000, 32'hffffffff);
    rd("irq mask", 12'h054, 32'h0, 32'hffffffff);
    apb(1'b1, 12'h03c, 32'hffffffff);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    apb(1'b0, 12'h03c, 32'h0);
    chk("unmapped data", 32'h0, rdat);
    $display("test reset done");
    apb(1'b1, 12'h054, 32'h1);
    apb(1'b1, 12'h038, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      exp_msgs = msgs + 1;
      iq_fetch_err_in <= (i == 0);
      iq_desc_err_in <= (i == 1);
      @(posedge clk_in);
      iq_fetch_err_in <= 1'b0;
      iq_desc_err_in <= 1'b0;
      tick(3);
      chk("queue msg", exp_msgs, msgs);
      chk("irq on", 32'h1, {31'h0, irq_out});
      rd("queue flag", 12'h034, 32'h10, 32'hffffffff);
      apb(1'b1, 12'h034, 32'h0);
      rd("queue kept", 12'h034, 32'h10, 32'hffffffff);
      apb(1'b1, 12'h034, 32'h10);
      rd("queue clear", 12'h034, 32'h0, 32'hffffffff);
      rd("irq bit", 12'h050, 32'h1, 32'h1);
      apb(1'b1, 12'h050, 32'h3f);
      tick(2);
      chk("irq off", 32'h0, {31'h0, irq_out});
    end
    $display("test queue done");
    exp_msgs = msgs;
    adv_first_rec_in <= 1'b1;
    adv_overflow_in <= 1'b1;
    rec_overflow_in <= 1'b1;
    @(posedge clk_in);
    adv_first_rec_in <= 1'b0;
    adv_overflow_in <= 1'b0;
    rec_overflow_in <= 1'b0;
    tick(3);
    rd("overflow", 12'h034, 32'h1, 32'hffffffff);
    chk("overflow msg", exp_msgs, msgs);
    apb(1'b1, 12'h034, 32'h0);
    rd("overflow kept", 12'h034, 32'h1, 32'hffffffff);
    apb(1'b1, 12'h034, 32'h1);
    rd("overflow clear", 12'h034, 32'h0, 32'hffffffff);
    $display("test overflow done");
    v = 8'($random(seed));
    if (v == 8'h00)
      v = 8'h40;
    low = 8;
    for (i = 7; i >= 0; i--)
      if (v[i])
        low = i;
    exp_msgs = msgs + 1;
    fault_flags_in <= v;
    tick(4);
    chk("fault msg", exp_msgs, msgs);
    rd("pending", 12'h034, low << 8 | 2, 32'hffffffff);
    fault_flags_in <= 8'hff;
    tick(4);
    rd("index held", 12'h034, low << 8 | 2, 32'hffffffff);
    chk("no new msg", exp_msgs, msgs);
    rd("irq ppf", 12'h050, 32'h8, 32'h8);
    chk("irq masked", 32'h0, {31'h0, irq_out});
    fault_flags_in <= 8'h00;
    tick(4);
    rd("none pending", 12'h034, 32'h0, 32'h000000ff);
    $display("test primary done");
    apb(1'b1, 12'h038, 32'h80000000);
    exp_msgs = msgs;
    fault_flags_in <= 8'h80;
    tick(4);
    chk("masked msg", exp_msgs, msgs);
    rd("held", 12'h038, 32'hc0000000, 32'hffffffff);
    apb(1'b1, 12'h038, 32'h0);
    tick(3);
    chk("unmasked msg", exp_msgs + 1, msgs);
    rd("served", 12'h038, 32'h0, 32'hffffffff);
    rd("index top", 12'h034, 32'h702, 32'hffffffff);
    $display("test mask done");
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    failures++;
    tally_and_finish();
  end
endmodule
